/* hw/cmc_regs.vh */
// constants for the bus transceiver mode control block
`ifndef CMC_REGS_VH
`define CMC_REGS_VH
// transceiver modes
`define CMC_TRX_OFF      2'h0
`define CMC_TRX_WAKE     2'h1
`define CMC_TRX_NORMAL   2'h2
`define CMC_TRX_RXONLY   2'h3
// chip operating modes
`define CMC_OP_INIT      3'h0
`define CMC_OP_NORMAL    3'h1
`define CMC_OP_SLEEP     3'h2
`define CMC_OP_RESTART   3'h3
`define CMC_OP_STOP      3'h4
`define CMC_OP_FAILSAFE  3'h5
`define CMC_OP_SWFLASH   3'h6
`define CMC_OP_FACTORY   3'h7
// software development mode is flagged separately from the operating mode code
// diagnostic codes
`define CMC_DIAG_NONE    3'h0
`define CMC_DIAG_TX_GND  3'h1
`define CMC_DIAG_RX_FLT  3'h2
`define CMC_DIAG_LOCAL   3'h3
`define CMC_DIAG_CLAMP   3'h4
// wake interrupt register address code
`define CMC_WAKE_REG_ADDR 3'h0
// times in ns
`define CMC_CLK_PERIOD_NS 10
`define CMC_WAKE_FILTER_NS 5000
`define CMC_TX_TIMEOUT_NS  2000000
`endif

/* hw/cmc_filter.v */
// counter that qualifies a level held for longer than a limit
`timescale 1ns/1ps
module cmc_filter #(
    parameter WIDTH = 20,
    parameter LIMIT = 500
) (
    input  wire clock,
    input  wire rst,
    input  wire enable,
    input  wire level_in,
    output reg  expired
);
    reg [WIDTH-1:0] count_reg;
    reg             prev_reg;

    // restart on each edge of the watched level
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= {WIDTH{1'b0}};
            prev_reg  <= 1'b0;
            expired   <= 1'b0;
        end else begin
            prev_reg <= level_in;
            if (!enable || !level_in || (level_in != prev_reg)) begin // see RULE23
                count_reg <= {WIDTH{1'b0}};
                expired   <= 1'b0;
            end else if (count_reg >= LIMIT[WIDTH-1:0]) begin
                expired <= 1'b1;
            end else begin
                count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

/* hw/cmc_mode_allow.v */
// checks a transceiver mode against the chip operating mode
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_mode_allow (
    input  wire [2:0] op_mode,
    input  wire       swdev_mode,
    input  wire [1:0] trx_mode,
    output reg        allowed
);
    always @* begin
        allowed = 1'b0;
        case (op_mode)
            `CMC_OP_INIT, `CMC_OP_FACTORY: allowed = (trx_mode == `CMC_TRX_OFF); // see RULE16
            `CMC_OP_FAILSAFE: allowed = (trx_mode == `CMC_TRX_WAKE);
            `CMC_OP_SWFLASH:  allowed = (trx_mode == `CMC_TRX_NORMAL); // see RULE1
            `CMC_OP_STOP, `CMC_OP_SLEEP, `CMC_OP_RESTART:
                allowed = (trx_mode == `CMC_TRX_OFF) || (trx_mode == `CMC_TRX_WAKE); // see RULE5
            `CMC_OP_NORMAL:   allowed = 1'b1;
            default:          allowed = 1'b0;
        endcase
        if (swdev_mode && trx_mode == `CMC_TRX_NORMAL) begin
            allowed = 1'b1;
        end
    end
endmodule

/* hw/cmc_can_mode_ctrl.v */
// transceiver mode, wake and fault control for a high-speed bus transceiver
// Operation
// RULE1 - normal mode only by command, in normal, flash or development operating mode (code forces normal in flash mode without a command)
// RULE2 - in normal mode the bus drivers follow the transmit input
// RULE3 - receive output shows bus level; receive output faults reach diagnostics
// RULE4 - common-mode stabilizer on only in normal or receive-only mode
// RULE5 - wake capable by command in stop/sleep/restart/normal; forced in fail-safe
// RULE6 - after a bus wake, re-arm wake capable only via normal, rx-only or off
// RULE7 - sleep wake past filter: go restart, receive output low, wake flag set
// RULE8 - wake out of sleep keeps interrupt output high
// RULE9 - wake source readable at wake interrupt register code 000
// RULE10 - stop wake: flag set, receive low, interrupt low unless masked, stay stop
// RULE11 - restart or fail-safe wake: flag set, go restart, interrupt high, receive low
// RULE12 - normal wake: flag set, interrupt low unless masked, receive low, stay normal
// RULE13 - off selectable in stop/sleep/restart/normal, forced in init/factory; wakes ignored
// RULE14 - receive-only by command: driver off, receiver still active
// RULE15 - supply below turn-off threshold: both bus pins high impedance
// RULE16 - transceiver mode restricted by operating mode column
// RULE17 - normal to sleep or stop switches to low-power wake receiver
// RULE18 - wake during go-to-sleep command is kept and sleep becomes restart
// RULE19 - software sets wake capable before sleep, not in the same command
// RULE20 - local or dominant clamp failure forces receive-only and is reported (code forces receive-only only in normal operating or development mode)
// RULE21 - transmit time-out reported with the transmit-shorted-to-ground code
// RULE22 - transmit dominant too long stops driving until mode command re-activates
// RULE23 - filter and time-out are restartable cycle counters with parameter limits
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_can_mode_ctrl #(
    parameter WAKE_CYCLES = (`CMC_WAKE_FILTER_NS + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS,
    parameter TXTO_CYCLES = (`CMC_TX_TIMEOUT_NS + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS,
    parameter CNT_WIDTH   = 18
) (
    input  wire       clock,
    input  wire       rst,
    input  wire [2:0] op_mode,
    input  wire       swdev_mode,
    input  wire       mode_cmd_valid,
    input  wire [1:0] mode_cmd,
    input  wire       sleep_cmd_busy,
    input  wire       bus_transmit_input,
    input  wire       bus_rx_level,
    input  wire       wake_rx_level,
    input  wire       rx_pin_fault,
    input  wire       local_fault,
    input  wire       bus_clamp_fault,
    input  wire       supply_turnoff_threshold,
    input  wire       wake_int_mask,
    input  wire       wake_reg_read,
    input  wire [2:0] wake_reg_addr,
    input  wire       wake_flag_clear,
    output reg  [1:0] trx_mode_reg,
    output reg        bus_drive_dominant_reg,
    output reg        bus_driver_en_reg,
    output reg        bus_receiver_en_reg,
    output reg        wake_receiver_en_reg,
    output reg        stabilizer_en_reg,
    output reg        bus_receive_output_reg,
    output reg        bus_wake_flag_reg,
    output reg        wake_reg_data_reg,
    output reg        int_n_reg,
    output reg        restart_req_reg,
    output reg  [2:0] diag_code_reg,
    output reg        tx_timeout_reg
);
    wire       cmd_allowed;
    wire       wake_seen;
    wire       txto_hit;
    reg  [1:0] mode_next;
    reg        wake_lock_reg;
    reg        pending_sleep_wake_reg;
    reg  [2:0] prev_op_reg;

    // transmit is dominant low
    wire tx_dominant = ~bus_transmit_input;
    wire wake_listen = (trx_mode_reg == `CMC_TRX_WAKE) && !supply_turnoff_threshold;

    cmc_mode_allow u_allow (
        .op_mode    (op_mode),
        .swdev_mode (swdev_mode),
        .trx_mode   (mode_cmd),
        .allowed    (cmd_allowed)
    );

    cmc_filter #(.WIDTH(CNT_WIDTH), .LIMIT(WAKE_CYCLES)) u_wake_filt (
        .clock    (clock),
        .rst      (rst),
        .enable   (wake_listen),
        .level_in (wake_rx_level),
        .expired  (wake_seen)
    ); // see RULE7

    cmc_filter #(.WIDTH(CNT_WIDTH), .LIMIT(TXTO_CYCLES)) u_txto (
        .clock    (clock),
        .rst      (rst),
        .enable   (trx_mode_reg == `CMC_TRX_NORMAL),
        .level_in (tx_dominant),
        .expired  (txto_hit)
    ); // see RULE22

    wire wake_event = wake_seen && !wake_lock_reg && !bus_wake_flag_reg;

    always @* begin
        mode_next = trx_mode_reg;
        if (mode_cmd_valid && cmd_allowed) begin
            // re-arm wake capable only after leaving it once a wake occurred
            if (!(mode_cmd == `CMC_TRX_WAKE && wake_lock_reg)) begin // see RULE6
                mode_next = mode_cmd; // see RULE1 see RULE5 see RULE13 see RULE14
            end
        end
        if ((local_fault || bus_clamp_fault) &&
            (op_mode == `CMC_OP_NORMAL || swdev_mode)) begin
            mode_next = `CMC_TRX_RXONLY; // see RULE20
        end
        case (op_mode)
            `CMC_OP_INIT, `CMC_OP_FACTORY: mode_next = `CMC_TRX_OFF; // see RULE13
            `CMC_OP_FAILSAFE: mode_next = `CMC_TRX_WAKE; // see RULE5
            `CMC_OP_SWFLASH:  mode_next = `CMC_TRX_NORMAL;
            `CMC_OP_STOP, `CMC_OP_SLEEP, `CMC_OP_RESTART: begin
                // only off or wake capable in low-power modes unless development mode is flagged
                if (!swdev_mode && (mode_next == `CMC_TRX_NORMAL || mode_next == `CMC_TRX_RXONLY)) begin
                    mode_next = `CMC_TRX_WAKE; // see RULE16 see RULE17
                end
            end
            default: mode_next = mode_next;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            trx_mode_reg           <= `CMC_TRX_OFF;
            bus_drive_dominant_reg <= 1'b0;
            bus_driver_en_reg      <= 1'b0;
            bus_receiver_en_reg    <= 1'b0;
            wake_receiver_en_reg   <= 1'b0;
            stabilizer_en_reg      <= 1'b0;
            bus_receive_output_reg <= 1'b1;
            bus_wake_flag_reg      <= 1'b0;
            wake_reg_data_reg      <= 1'b0;
            int_n_reg              <= 1'b1;
            restart_req_reg        <= 1'b0;
            diag_code_reg          <= `CMC_DIAG_NONE;
            tx_timeout_reg         <= 1'b0;
            wake_lock_reg          <= 1'b0;
            pending_sleep_wake_reg <= 1'b0;
            prev_op_reg            <= `CMC_OP_INIT;
        end else begin
            trx_mode_reg <= mode_next;
            prev_op_reg  <= op_mode;
            restart_req_reg <= 1'b0;

            // timeout latches until a mode command re-activates the driver
            if (txto_hit) begin
                tx_timeout_reg <= 1'b1; // see RULE22
            end else if (mode_cmd_valid && cmd_allowed && mode_cmd == `CMC_TRX_NORMAL) begin
                tx_timeout_reg <= 1'b0;
            end

            if (mode_next == `CMC_TRX_NORMAL || mode_next == `CMC_TRX_RXONLY ||
                mode_next == `CMC_TRX_OFF) begin
                wake_lock_reg <= 1'b0; // see RULE6
            end

            // wake flag: set wins over clear
            if (wake_event) begin
                bus_wake_flag_reg <= 1'b1;
                wake_lock_reg     <= 1'b1;
            end else if (wake_flag_clear) begin
                bus_wake_flag_reg <= 1'b0;
            end

            if (wake_reg_read) begin
                wake_reg_data_reg <= (wake_reg_addr == `CMC_WAKE_REG_ADDR) ? bus_wake_flag_reg : 1'b0; // see RULE9
            end

            // wake during a go-to-sleep transfer is held and turns sleep into restart
            if (wake_event && sleep_cmd_busy) begin
                pending_sleep_wake_reg <= 1'b1; // see RULE18
            end else if (!sleep_cmd_busy) begin
                pending_sleep_wake_reg <= 1'b0;
            end

            if (wake_event) begin
                case (op_mode)
                    `CMC_OP_SLEEP, `CMC_OP_RESTART, `CMC_OP_FAILSAFE: begin
                        restart_req_reg <= 1'b1; // see RULE7 see RULE11
                    end
                    `CMC_OP_STOP, `CMC_OP_NORMAL: begin
                        int_n_reg <= wake_int_mask; // see RULE10 see RULE12
                    end
                    default: restart_req_reg <= 1'b0;
                endcase
            end else if (pending_sleep_wake_reg && op_mode == `CMC_OP_SLEEP) begin
                restart_req_reg <= 1'b1; // see RULE18
            end else if (wake_flag_clear) begin
                int_n_reg <= 1'b1; // see RULE8
            end

            // drivers, receivers and stabilizer
            if (supply_turnoff_threshold) begin
                bus_driver_en_reg    <= 1'b0; // see RULE15
                bus_receiver_en_reg  <= 1'b0;
                wake_receiver_en_reg <= 1'b0;
                stabilizer_en_reg    <= 1'b0;
            end else begin
                bus_driver_en_reg    <= (mode_next == `CMC_TRX_NORMAL) && !tx_timeout_reg && !txto_hit; // see RULE14
                bus_receiver_en_reg  <= (mode_next == `CMC_TRX_NORMAL) || (mode_next == `CMC_TRX_RXONLY);
                wake_receiver_en_reg <= (mode_next == `CMC_TRX_WAKE); // see RULE17
                stabilizer_en_reg    <= (mode_next == `CMC_TRX_NORMAL) || (mode_next == `CMC_TRX_RXONLY); // see RULE4
            end
            bus_drive_dominant_reg <= (mode_next == `CMC_TRX_NORMAL) && !tx_timeout_reg && !txto_hit &&
                                      tx_dominant && !supply_turnoff_threshold; // see RULE2

            // receive output follows bus, held low after a wake
            if (bus_wake_flag_reg || wake_event) begin
                bus_receive_output_reg <= 1'b0; // see RULE7 see RULE10 see RULE11 see RULE12
            end else if (trx_mode_reg == `CMC_TRX_NORMAL || trx_mode_reg == `CMC_TRX_RXONLY) begin
                bus_receive_output_reg <= bus_rx_level; // see RULE3
            end else begin
                bus_receive_output_reg <= 1'b1;
            end

            // diagnostics, priority timeout over others
            if (txto_hit || tx_timeout_reg) begin
                diag_code_reg <= `CMC_DIAG_TX_GND; // see RULE21
            end else if (bus_clamp_fault) begin
                diag_code_reg <= `CMC_DIAG_CLAMP; // see RULE20
            end else if (local_fault) begin
                diag_code_reg <= `CMC_DIAG_LOCAL;
            end else if (rx_pin_fault) begin
                diag_code_reg <= `CMC_DIAG_RX_FLT; // see RULE3
            end else begin
                diag_code_reg <= `CMC_DIAG_NONE;
            end
        end
    end
endmodule

/* sim/cmc_can_mode_ctrl_sva.sv */
// assertion checker for the transceiver mode control block
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_can_mode_ctrl_sva (
    input logic       clock,
    input logic       rst,
    input logic [2:0] op_mode,
    input logic       swdev_mode,
    input logic       supply_turnoff_threshold,
    input logic [1:0] trx_mode_reg,
    input logic       bus_drive_dominant_reg,
    input logic       bus_driver_en_reg,
    input logic       bus_receiver_en_reg,
    input logic       stabilizer_en_reg,
    input logic       bus_receive_output_reg,
    input logic       bus_wake_flag_reg,
    input logic       int_n_reg,
    input logic       restart_req_reg,
    input logic [2:0] diag_code_reg,
    input logic       tx_timeout_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_low_supply;
        supply_turnoff_threshold ##1 supply_turnoff_threshold;
    endsequence
    sequence s_wake_rise;
        $rose(bus_wake_flag_reg);
    endsequence
    AST_STAB: assert property (stabilizer_en_reg |-> trx_mode_reg[1]) else $error("stabilizer on");
    AST_NORM_ENTRY: assert property (trx_mode_reg == `CMC_TRX_NORMAL && $past(trx_mode_reg) != `CMC_TRX_NORMAL
        |-> $past(op_mode) == `CMC_OP_NORMAL || $past(op_mode) == `CMC_OP_SWFLASH || $past(swdev_mode))
        else $error("normal entered in wrong mode");
    AST_DRIVE: assert property (bus_drive_dominant_reg |-> bus_driver_en_reg && trx_mode_reg == `CMC_TRX_NORMAL)
        else $error("drive outside normal");
    AST_RXONLY: assert property (trx_mode_reg == `CMC_TRX_RXONLY |-> !bus_driver_en_reg)
        else $error("driver on in receive-only");
    AST_SUPPLY: assert property (s_low_supply |-> !bus_driver_en_reg && !bus_receiver_en_reg)
        else $error("bus active at low supply");
    AST_FORCE_OFF: assert property ((op_mode == `CMC_OP_INIT || op_mode == `CMC_OP_FACTORY) && !swdev_mode
        && $stable(op_mode) |-> trx_mode_reg == `CMC_TRX_OFF) else $error("off not forced");
    AST_FORCE_WAKE: assert property (op_mode == `CMC_OP_FAILSAFE && !swdev_mode && $stable(op_mode)
        |-> trx_mode_reg == `CMC_TRX_WAKE) else $error("wake capable not forced");
    AST_WAKE_RX: assert property (s_wake_rise |-> !bus_receive_output_reg)
        else $error("receive output high on wake");
    AST_SLEEP_RESTART: assert property (s_wake_rise ##0 ($past(op_mode) == `CMC_OP_SLEEP) |-> ##[0:1] restart_req_reg)
        else $error("no restart request");
    AST_SLEEP_NOINT: assert property (s_wake_rise ##0 ($past(op_mode) == `CMC_OP_SLEEP) |-> int_n_reg)
        else $error("interrupt on sleep wake");
    AST_TIMEOUT: assert property ($rose(tx_timeout_reg) |-> diag_code_reg == `CMC_DIAG_TX_GND
        && !bus_drive_dominant_reg) else $error("timeout handling wrong");
    AST_OFF_NOWAKE: assert property (trx_mode_reg == `CMC_TRX_OFF && $past(trx_mode_reg) == `CMC_TRX_OFF
        |-> !$rose(bus_wake_flag_reg)) else $error("wake in off");
endmodule
bind cmc_can_mode_ctrl cmc_can_mode_ctrl_sva u_sva (.*);

/* sim/cmc_host_model.sv */
// protocol controller model that holds the transmit line dominant for a count
`timescale 1ns/1ps
module cmc_host_model (
    input  logic       clock,
    input  logic       start,
    input  logic [7:0] dom_cycles,
    output logic       bus_transmit_input
);
    logic [7:0] cnt = 8'h00;
    // start is sampled on the rising edge, so the line changes just after it
    always @(posedge clock) begin
        if (start) cnt <= dom_cycles;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
    assign bus_transmit_input = (cnt == 8'h00);
endmodule

/* sim/cmc_can_mode_ctrl_tb.sv */
// self-checking bench for the transceiver mode control block
`timescale 1ns/1ps
module cmc_can_mode_ctrl_tb;
    logic clock = 0, rst = 1, swdev_mode = 0, mode_cmd_valid = 0, sleep_cmd_busy = 0, bus_rx_level = 1;
    logic wake_rx_level = 0, rx_pin_fault = 0, local_fault = 0, bus_clamp_fault = 0, wake_int_mask = 0;
    logic supply_turnoff_threshold = 0, wake_reg_read = 0, wake_flag_clear = 0, start = 0;
    logic [2:0] op_mode = 3'h1, wake_reg_addr = 3'h0;
    logic [1:0] mode_cmd = 2'h0;
    logic [7:0] dom = 8'h19;
    wire [1:0] trx_mode_reg;
    wire [2:0] diag_code_reg;
    wire bus_transmit_input, bus_drive_dominant_reg, bus_driver_en_reg, bus_receiver_en_reg, wake_receiver_en_reg;
    wire stabilizer_en_reg, bus_receive_output_reg, bus_wake_flag_reg, wake_reg_data_reg, int_n_reg;
    wire restart_req_reg, tx_timeout_reg;
    int errors = 0, total_checks = 0, cycles = 0, rr_count = 0, rr_base = 0;
    // row: op_mode[7:5] swdev[4] command[3:2] expected mode[1:0]
    logic [7:0] rows [12] = '{8'h2a, 8'h2f, 8'h20, 8'h25, 8'h80, 8'h68, 8'h65, 8'hc2, 8'h08, 8'ha1, 8'he4, 8'h7a};
    cmc_can_mode_ctrl #(.WAKE_CYCLES(8), .TXTO_CYCLES(20)) dut (.*);
    cmc_host_model host (.clock(clock), .start(start), .dom_cycles(dom), .bus_transmit_input(bus_transmit_input));
    initial forever #5 clock = ~clock;
    always @(posedge clock) if (restart_req_reg === 1'b1) rr_count <= rr_count + 1;
    always @(posedge clock) if (++cycles == 5000) begin errors++; conclude(); end
    task automatic chk(input logic [2:0] g, input logic [2:0] e);
        total_checks++;
        if (g !== e) begin errors++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end
    endtask
    task automatic cyc(input int n); repeat (n) @(negedge clock); endtask
    task automatic cmd(input logic [1:0] c);
        mode_cmd_valid = 1; mode_cmd = c; cyc(1); mode_cmd_valid = 0; cyc(2);
    endtask
    task automatic wake(); wake_rx_level = 1; cyc(12); wake_rx_level = 0; cyc(2); endtask
    task automatic clr(); wake_flag_clear = 1; cyc(1); wake_flag_clear = 0; cyc(1); endtask
    task automatic done(input string s); $display("test %s finished", s); endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        cyc(5); rst = 0; cyc(1);
        foreach (rows[i]) begin
            {op_mode, swdev_mode} = rows[i][7:4]; cyc(2); cmd(rows[i][3:2]);
            chk(trx_mode_reg, rows[i][1:0]);
            chk(stabilizer_en_reg, rows[i][1]);
            chk(bus_driver_en_reg, rows[i][1:0] == 2'h2);
            chk(wake_receiver_en_reg, rows[i][1:0] == 2'h1);
        end
        done("mode table");
        {op_mode, swdev_mode} = 4'h2; cmd(2'h0); cmd(2'h1); wake();
        chk(bus_wake_flag_reg, 1); chk(bus_receive_output_reg, 0); chk(int_n_reg, 0);
        wake_reg_read = 1; cyc(1); wake_reg_read = 0; cyc(1);
        chk(wake_reg_data_reg, 1); clr(); chk(bus_wake_flag_reg, 0); done("normal wake");
        cmd(2'h2); start = 1; cyc(1); start = 0; cyc(3);
        chk(bus_drive_dominant_reg, 1); cyc(24);
        chk(tx_timeout_reg, 1); chk(diag_code_reg, 1); chk(bus_drive_dominant_reg, 0);
        cmd(2'h2); chk(tx_timeout_reg, 0); done("timeout");
        bus_rx_level = 0; cyc(2); chk(bus_receive_output_reg, 0); bus_rx_level = 1; cyc(2);
        chk(bus_receive_output_reg, 1); rx_pin_fault = 1; cyc(2); chk(diag_code_reg, 2); rx_pin_fault = 0;
        for (int j = 0; j < 2; j++) begin
            {bus_clamp_fault, local_fault} = 2'h1 << j; cyc(2);
            chk(trx_mode_reg, 3); chk(diag_code_reg, 3'h3 + j);
            {bus_clamp_fault, local_fault} = 2'h0; cmd(2'h2);
        end
        supply_turnoff_threshold = 1; cyc(2); chk(bus_driver_en_reg, 0); chk(bus_receiver_en_reg, 0);
        supply_turnoff_threshold = 0; cyc(2); done("faults");
        cmd(2'h0); cmd(2'h1); op_mode = 3'h4; wake_int_mask = 1; wake();
        chk(bus_wake_flag_reg, 1); chk(int_n_reg, 1); chk(bus_receive_output_reg, 0); clr();
        wake_int_mask = 0; cmd(2'h0); wake(); chk(bus_wake_flag_reg, 0); done("stop and off");
        op_mode = 3'h1; cmd(2'h1); op_mode = 3'h2; rr_base = rr_count; wake();
        chk(rr_count - rr_base, 1); chk(int_n_reg, 1); chk(bus_wake_flag_reg, 1); clr();
        op_mode = 3'h1; cmd(2'h0); cmd(2'h1); sleep_cmd_busy = 1; rr_base = rr_count; wake();
        // the sleep transfer ends and the chip reaches sleep in the same cycle
        {op_mode, sleep_cmd_busy} = 4'h4; cyc(2);
        chk(rr_count - rr_base, 1); chk(bus_wake_flag_reg, 1); clr(); done("sleep wake");
        rst = 1; cyc(2);
        chk(trx_mode_reg, 0); chk(int_n_reg, 1); chk(diag_code_reg, 0); chk(bus_receive_output_reg, 1);
        done("reset");
        conclude();
    end
endmodule
